// file: pkg/vic_pkg.sv
// constants, register map and reset values for the vectored request controller
package request_ctl_pkg;
    localparam int NUM_SRC = 32;
    localparam int NUM_SLOT = 16;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int SRC_IDX_W = 5;
    localparam int SLOT_IDX_W = 4;
    localparam int SLOT_CTL_W = 6;
    localparam int SLOT_EN_BIT = 5;
    localparam int NUM_EVT = 3;
    // event bit positions
    localparam int EVT_FAST_RISE = 0;
    localparam int EVT_IRQ_RISE = 1;
    localparam int EVT_BUS_ERR = 2;
    // fixed channel numbers
    localparam int CH_WATCHDOG = 0;
    localparam int CH_SOFTWARE = 1;
    localparam int CH_DBG_RX = 2;
    localparam int CH_DBG_TX = 3;
    localparam int CH_TIMER0 = 4;
    localparam int CH_TIMER1 = 5;
    localparam int CH_SERIAL0 = 6;
    localparam int CH_FIRST_OTHER = 7;
    // byte offsets
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h000;
    localparam logic [11:0] OFF_FAST_STATUS = 12'h004;
    localparam logic [11:0] OFF_RAW_STATUS = 12'h008;
    localparam logic [11:0] OFF_CLASS_SELECT = 12'h00C;
    localparam logic [11:0] OFF_ENABLE = 12'h010;
    localparam logic [11:0] OFF_SOFT_REQUEST = 12'h018;
    localparam logic [11:0] OFF_VECTOR_ADDR = 12'h030;
    localparam logic [11:0] OFF_DEFAULT_ADDR = 12'h034;
    localparam logic [11:0] OFF_EVT_STATUS = 12'h040;
    localparam logic [11:0] OFF_EVT_CLEAR = 12'h044;
    localparam logic [11:0] OFF_EVT_ENABLE = 12'h048;
    localparam logic [11:0] OFF_SLOT_ADDR_BASE = 12'h100;
    localparam logic [11:0] OFF_SLOT_CTL_BASE = 12'h200;
    localparam logic [11:0] SLOT_ARRAY_MASK = 12'hFC3;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [5:0] RST_SLOT_CTL = 6'h00;
    localparam logic [2:0] RST_EVT = 3'h0;
endpackage

// file: design/vectored_request_controller.sv
// vectored request controller: source sorting, slot priority, vector words, apb slave
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module vectored_request_controller (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [request_ctl_pkg::ADDR_W-1:0] paddr,
    input wire logic [request_ctl_pkg::DATA_W-1:0] pwdata,
    output logic [request_ctl_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic watchdog_request,
    input wire logic debug_comm_receive,
    input wire logic debug_comm_transmit,
    input wire logic [3:0] timer0_match_flag,
    input wire logic [3:0] timer0_capture_flag,
    input wire logic [3:0] timer1_match_flag,
    input wire logic [3:0] timer1_capture_flag,
    input wire logic rx_line_status_flag,
    input wire logic tx_holding_empty_flag,
    input wire logic rx_data_available_flag,
    input wire logic char_timeout_flag,
    input wire logic [request_ctl_pkg::NUM_SRC-1:request_ctl_pkg::CH_FIRST_OTHER] other_request,
    output logic fast_request,
    output logic irq_request,
    output logic event_irq
);
    import request_ctl_pkg::*;

    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] class_select;
    logic [NUM_SRC-1:0] enable;
    logic [NUM_SRC-1:0] soft_request;
    logic [NUM_SRC-1:0] fast_status;
    logic [NUM_SRC-1:0] irq_status;
    logic [DATA_W-1:0] slot_addr [NUM_SLOT];
    logic [SLOT_CTL_W-1:0] slot_ctl [NUM_SLOT];
    logic [NUM_SLOT-1:0] slot_hit;
    logic [DATA_W-1:0] default_addr;
    logic [DATA_W-1:0] vector_addr;
    logic [NUM_EVT-1:0] evt_status;
    logic [NUM_EVT-1:0] evt_enable;
    logic [NUM_EVT-1:0] evt_set;
    logic next_fast;
    logic next_irq;
    logic setup;
    logic wr_en;
    logic [DATA_W-1:0] next_rdata;
    logic next_err;
    logic slot_addr_sel;
    logic slot_ctl_sel;
    logic [SLOT_IDX_W-1:0] slot_idx;

    // one request line per peripheral, two for debug comms (receive and transmit), each the or of its own flags
    always_comb begin
        // upper channels take the other lines as they stand; low bits filled below
        raw = {other_request, 7'h00};
        raw[CH_WATCHDOG] = watchdog_request;
        raw[CH_SOFTWARE] = 1'b0;
        raw[CH_DBG_RX] = debug_comm_receive;
        raw[CH_DBG_TX] = debug_comm_transmit;
        raw[CH_TIMER0] = |{timer0_match_flag, timer0_capture_flag};
        raw[CH_TIMER1] = |{timer1_match_flag, timer1_capture_flag};
        raw[CH_SERIAL0] = rx_line_status_flag | tx_holding_empty_flag
                          | rx_data_available_flag | char_timeout_flag;
        // software requests may raise any channel; channel 1 has no other source
        raw = raw | soft_request;
    end

    // sort each enabled source into the fast or the irq class
    // levels only: a source that drops its flag drops out with no latching
    assign fast_status = raw & enable & class_select;
    assign irq_status = raw & enable & ~class_select;

    // a slot requests when it is on and its chosen source is in the irq class
    generate
        for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
            assign slot_hit[s] = slot_ctl[s][SLOT_EN_BIT]
                                 & irq_status[slot_ctl[s][SRC_IDX_W-1:0]];
        end
    endgenerate

    // walk from the lowest priority upward so the lowest slot number wins
    always_comb begin
        vector_addr = default_addr;
        for (int s = NUM_SLOT - 1; s >= 0; s--) begin
            if (slot_hit[s]) begin
                vector_addr = slot_addr[s];
            end
        end
    end

    // merged outputs; fast and irq lines are separate so the core can rank them
    assign next_fast = |fast_status;
    assign next_irq = |irq_status;

    // outputs registered to keep glitches off the core's request pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_request <= 1'b0;
            irq_request <= 1'b0;
        end else begin
            fast_request <= next_fast;
            irq_request <= next_irq;
        end
    end

    // apb phases: data is prepared in setup so it leaves a flop in access
    assign setup = psel & ~penable;
    assign pready = psel & penable;
    assign wr_en = psel & penable & pwrite;
    assign slot_idx = paddr[SLOT_IDX_W+1:2];
    assign slot_addr_sel = (paddr & SLOT_ARRAY_MASK) == OFF_SLOT_ADDR_BASE;
    assign slot_ctl_sel = (paddr & SLOT_ARRAY_MASK) == OFF_SLOT_CTL_BASE;

    // read decode; unmapped offsets read zero and flag an error
    always_comb begin
        next_rdata = RST_WORD;
        next_err = 1'b0;
        if (paddr == OFF_IRQ_STATUS) begin
            next_rdata = irq_status;
        end else if (paddr == OFF_FAST_STATUS) begin
            next_rdata = fast_status;
        end else if (paddr == OFF_RAW_STATUS) begin
            next_rdata = raw;
        end else if (paddr == OFF_CLASS_SELECT) begin
            next_rdata = class_select;
        end else if (paddr == OFF_ENABLE) begin
            next_rdata = enable;
        end else if (paddr == OFF_SOFT_REQUEST) begin
            next_rdata = soft_request;
        end else if (paddr == OFF_VECTOR_ADDR) begin
            next_rdata = vector_addr;
        end else if (paddr == OFF_DEFAULT_ADDR) begin
            next_rdata = default_addr;
        end else if (paddr == OFF_EVT_STATUS) begin
            next_rdata = {{(DATA_W-NUM_EVT){1'b0}}, evt_status};
        end else if (paddr == OFF_EVT_CLEAR) begin
            next_rdata = RST_WORD;
        end else if (paddr == OFF_EVT_ENABLE) begin
            next_rdata = {{(DATA_W-NUM_EVT){1'b0}}, evt_enable};
        end else if (slot_addr_sel) begin
            next_rdata = slot_addr[slot_idx];
        end else if (slot_ctl_sel) begin
            next_rdata = {{(DATA_W-SLOT_CTL_W){1'b0}}, slot_ctl[slot_idx]};
        end else begin
            next_err = 1'b1;
        end
    end

    // read data and error are captured in setup and held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RST_WORD;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? RST_WORD : next_rdata;
            pslverr <= next_err;
        end
    end

    // class and enable settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            class_select <= RST_WORD;
            enable <= RST_WORD;
        end else if (wr_en) begin
            if (paddr == OFF_CLASS_SELECT) begin
                class_select <= pwdata;
            end else if (paddr == OFF_ENABLE) begin
                enable <= pwdata;
            end
        end
    end

    // software-raised requests, held until software lowers them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_request <= RST_WORD;
        end else if (wr_en && paddr == OFF_SOFT_REQUEST) begin
            soft_request <= pwdata;
        end
    end

    // default address shared by every non-vectored source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            default_addr <= RST_WORD;
        end else if (wr_en && paddr == OFF_DEFAULT_ADDR) begin
            default_addr <= pwdata;
        end
    end

    // slot routine addresses and slot controls
    // changing a slot while its source requests moves the vector at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int s = 0; s < NUM_SLOT; s++) begin
                slot_addr[s] <= RST_WORD;
                slot_ctl[s] <= RST_SLOT_CTL;
            end
        end else if (wr_en) begin
            if (slot_addr_sel) begin
                slot_addr[slot_idx] <= pwdata;
            end else if (slot_ctl_sel) begin
                slot_ctl[slot_idx] <= pwdata[SLOT_CTL_W-1:0];
            end
        end
    end

    // housekeeping events: rising fast, rising irq, bad bus access
    always_comb begin
        evt_set = RST_EVT;
        evt_set[EVT_FAST_RISE] = next_fast & ~fast_request;
        evt_set[EVT_IRQ_RISE] = next_irq & ~irq_request;
        evt_set[EVT_BUS_ERR] = pready & pslverr;
    end

    // sticky event bits; a set in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= RST_EVT;
        end else if (wr_en && paddr == OFF_EVT_CLEAR) begin
            evt_status <= (evt_status & ~pwdata[NUM_EVT-1:0]) | evt_set;
        end else begin
            evt_status <= evt_status | evt_set;
        end
    end

    // event enable mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_enable <= RST_EVT;
        end else if (wr_en && paddr == OFF_EVT_ENABLE) begin
            evt_enable <= pwdata[NUM_EVT-1:0];
        end
    end

    // level event output, high while any enabled sticky bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_irq <= 1'b0;
        end else begin
            event_irq <= |(evt_status & evt_enable);
        end
    end
endmodule
`default_nettype wire

// file: sim/vectored_request_controller_sva.sv
// port-level assertions for the vectored request controller
`timescale 1ns/1ps
`default_nettype none
module vectored_request_controller_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [request_ctl_pkg::ADDR_W-1:0] paddr,
    input wire logic [request_ctl_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic watchdog_request,
    input wire logic debug_comm_receive,
    input wire logic debug_comm_transmit,
    input wire logic [3:0] timer0_match_flag,
    input wire logic [3:0] timer0_capture_flag,
    input wire logic [3:0] timer1_match_flag,
    input wire logic [3:0] timer1_capture_flag,
    input wire logic rx_line_status_flag,
    input wire logic tx_holding_empty_flag,
    input wire logic rx_data_available_flag,
    input wire logic char_timeout_flag,
    input wire logic [request_ctl_pkg::NUM_SRC-1:request_ctl_pkg::CH_FIRST_OTHER] other_request,
    input wire logic fast_request,
    input wire logic irq_request
);
    import request_ctl_pkg::*;
    logic any_src;
    // soft requests are invisible here, so the bench keeps them out of enabled channels
    assign any_src = watchdog_request | debug_comm_receive | debug_comm_transmit | (|timer0_match_flag)
        | (|timer0_capture_flag) | (|timer1_match_flag) | (|timer1_capture_flag) | rx_line_status_flag
        | tx_holding_empty_flag | rx_data_available_flag | char_timeout_flag | (|other_request);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && penable |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready missing in access");
    property p_idle; !psel |-> !pready; endproperty
    a_idle: assert property (p_idle) else $error("pready while idle");
    property p_hold; psel && penable ##1 !psel |-> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data not held");
    property p_vec; psel && penable && paddr == OFF_VECTOR_ADDR |-> !pslverr; endproperty
    a_vec: assert property (p_vec) else $error("vector word refused");
    property p_hole; psel && penable && paddr == 12'h014 |-> pslverr; endproperty
    a_hole: assert property (p_hole) else $error("unmapped access not refused");
    property p_fast; $rose(fast_request) |-> $past(any_src); endproperty
    a_fast: assert property (p_fast) else $error("fast request without source");
    property p_irq; $rose(irq_request) |-> $past(any_src); endproperty
    a_irq: assert property (p_irq) else $error("irq request without source");
    property p_quiet; !any_src [*2] |=> !fast_request && !irq_request; endproperty
    a_quiet: assert property (p_quiet) else $error("output stuck after sources cleared");
endmodule
bind vectored_request_controller vectored_request_controller_sva vectored_request_controller_sva_inst (.pclk, .presetn,
    .psel, .penable, .paddr, .prdata, .pready, .pslverr, .watchdog_request, .debug_comm_receive, .debug_comm_transmit,
    .timer0_match_flag, .timer0_capture_flag, .timer1_match_flag, .timer1_capture_flag, .rx_line_status_flag,
    .tx_holding_empty_flag, .rx_data_available_flag, .char_timeout_flag, .other_request, .fast_request, .irq_request);
`default_nettype wire

// file: sim/core_model.sv
// processor core model: picks which request line it would service
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fast_request,
    input wire logic irq_request,
    output logic [1:0] taken
);
    // fast entry wins when both lines are up; ranking is the core's job here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken <= 2'b00;
        end else begin
            taken <= fast_request ? 2'b10 : {1'b0, irq_request};
        end
    end
endmodule
`default_nettype wire

// file: sim/vectored_request_controller_tb_top.sv
// self-checking bench for the vectored request controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; $display("MISMATCH %0t got %0h want %0h", $time, a, e); end end
module vectored_request_controller_tb_top;
    import request_ctl_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic wd = 1'b0, dbr = 1'b0, dbt = 1'b0, pready, pslverr, fast_request, irq_request, event_irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0] t0m = 4'h0, t0c = 4'h0, t1m = 4'h0, t1c = 4'h0, ser = 4'h0;
    logic [31:7] oth = '0;
    logic [1:0] taken;
    int err_count = 0, checks = 0, cyc = 0;
    vectored_request_controller vectored_request_controller_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .watchdog_request(wd), .debug_comm_receive(dbr),
        .debug_comm_transmit(dbt), .timer0_match_flag(t0m), .timer0_capture_flag(t0c), .timer1_match_flag(t1m),
        .timer1_capture_flag(t1c), .rx_line_status_flag(ser[0]), .tx_holding_empty_flag(ser[1]),
        .rx_data_available_flag(ser[2]), .char_timeout_flag(ser[3]), .other_request(oth), .fast_request,
        .irq_request, .event_irq);
    core_model core_model_inst (.pclk, .presetn, .fast_request, .irq_request, .taken);
    always #4 pclk = ~pclk;
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 3000) begin
            err_count++;
            final_report();
        end
    end
    task automatic final_report();
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one apb transfer; the idle edge at the end keeps the next setup off this release
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wt();
        repeat (2) @(posedge pclk);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        acc(1'b0, OFF_ENABLE, 0); `CHK(rd, RST_WORD)
        acc(1'b0, OFF_CLASS_SELECT, 0); `CHK(rd, RST_WORD)
        acc(1'b0, 12'h014, 0); `CHK({er, rd}, 33'h1_0000_0000)
        acc(1'b1, OFF_CLASS_SELECT, 32'h0000_0011);
        acc(1'b1, OFF_ENABLE, 32'h8000_007D);
        acc(1'b1, OFF_EVT_ENABLE, 32'h0000_0001);
        wd <= 1'b1;
        t0c <= 4'h8;
        wt(); `CHK({fast_request, irq_request}, 2'b10)
        acc(1'b0, OFF_FAST_STATUS, 0); `CHK(rd, 32'h0000_0011)
        `CHK(event_irq, 1'b1)
        acc(1'b1, OFF_EVT_CLEAR, 32'h0000_0001);
        @(posedge pclk); `CHK(event_irq, 1'b0)
        wd <= 1'b0;
        wt(); `CHK(fast_request, 1'b1)
        t0c <= 4'h0;
        wt(); `CHK(fast_request, 1'b0)
        // slots 0, 1 and 15 take the serial port, timer 1 and debug transmit
        acc(1'b1, OFF_SLOT_ADDR_BASE, 32'h0000_A000);
        acc(1'b1, OFF_SLOT_ADDR_BASE + 12'h004, 32'h0000_B000);
        acc(1'b1, OFF_SLOT_ADDR_BASE + 12'h03C, 32'h0000_F000);
        acc(1'b1, OFF_SLOT_CTL_BASE, 32'h0000_0026);
        acc(1'b1, OFF_SLOT_CTL_BASE + 12'h004, 32'h0000_0025);
        acc(1'b1, OFF_SLOT_CTL_BASE + 12'h03C, 32'h0000_0023);
        acc(1'b1, OFF_DEFAULT_ADDR, 32'h0000_D000);
        acc(1'b0, OFF_VECTOR_ADDR, 0); `CHK(rd, 32'h0000_D000)
        dbr <= 1'b1;
        t1m <= 4'h1;
        wt(); `CHK({fast_request, irq_request}, 2'b01)
        acc(1'b0, OFF_VECTOR_ADDR, 0); `CHK(rd, 32'h0000_B000)
        dbt <= 1'b1;
        acc(1'b0, OFF_VECTOR_ADDR, 0); `CHK(rd, 32'h0000_B000)
        for (int i = 0; i < 4; i++) begin
            ser <= 4'(1 << i);
            wt();
            acc(1'b0, OFF_VECTOR_ADDR, 0); `CHK(rd, 32'h0000_A000)
        end
        ser <= 4'h0;
        t1m <= 4'h0;
        wt(); acc(1'b0, OFF_VECTOR_ADDR, 0); `CHK(rd, 32'h0000_F000)
        dbt <= 1'b0;
        wt(); acc(1'b0, OFF_VECTOR_ADDR, 0); `CHK(rd, 32'h0000_D000)
        wd <= 1'b1;
        acc(1'b0, OFF_IRQ_STATUS, 0); `CHK(rd, 32'h0000_0004)
        `CHK({fast_request, irq_request, taken}, 4'b1110)
        wd <= 1'b0;
        dbr <= 1'b0;
        oth[31] <= 1'b1;
        wt(); acc(1'b0, OFF_IRQ_STATUS, 0); `CHK(rd, 32'h8000_0000)
        acc(1'b1, OFF_CLASS_SELECT, 32'h8000_0011);
        acc(1'b0, OFF_FAST_STATUS, 0); `CHK(rd, 32'h8000_0000)
        `CHK({fast_request, irq_request}, 2'b10)
        oth[31] <= 1'b0;
        wt(); `CHK({fast_request, irq_request}, 2'b00)
        `CHK(event_irq, 1'b1)
        acc(1'b0, OFF_EVT_STATUS, 0); `CHK(rd, 32'h0000_0007)
        acc(1'b1, OFF_EVT_ENABLE, 32'h0000_0000);
        @(posedge pclk); `CHK(event_irq, 1'b0)
        acc(1'b1, OFF_SOFT_REQUEST, 32'h0000_0002);
        wt(); acc(1'b0, OFF_RAW_STATUS, 0); `CHK(rd, 32'h0000_0002)
        final_report();
    end
endmodule
`default_nettype wire
